// File: rtl/dadc_port_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - serial clock pin is output with internal clock, input with external.
// - serial clock invert picks the edge on which serial data changes.
// - parallel mode drives the upper result bits, bits 8 to 11 too.
// - frame sync is an output, used only with the internal clock.
// - polarity low: sync high framing data, pulsed low after channel one.
// - polarity high: sync low while data valid, pulsed high after one.
// - external clock read cut by next result: data dropped, error pulsed.
// - bits twelve to fifteen float whenever serial mode is selected.
// - busy rises at start, falls when both results are latched.
// - end of conversion goes low as each channel finishes.
// - parallel bus and serial data pin enabled only while select and read are both low.
// - external serial clock ignored while chip select is high.
// - reset input high resets and aborts any conversion.
// - power down lets current conversion finish, then blocks new ones.
// - both results in a 32-bit register, msb first, order selectable.
// - external clock: data changes rising, valid falling; invert swaps.
// - serial clock pin is device clock or host supplied clock.
module dadc_port_ctrl
	import dadc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic reset_in,
	input wire logic power_down_in,
	input wire logic conv_start,
	input wire logic [RES_W-1:0] ch_a_result,
	input wire logic [RES_W-1:0] ch_b_result,
	input wire logic channel_order_select,
	input wire logic serial_parallel_select,
	input wire logic clock_source_select,
	input wire logic serial_clock_invert,
	input wire logic frame_sync_polarity,
	input wire logic cs_n,
	input wire logic rd_n,
	output logic busy,
	output logic end_of_conv_n,
	output logic power_saving,
	output logic [PIN_HI:PIN_LO] upper_out,
	output logic [PIN_HI:PIN_LO] upper_oe
);
	typedef struct packed {
		dadc_conv_state_type cv_state;
		logic [CONV_CNT_W-1:0] cv_cnt;
		logic [EOC_CNT_W-1:0] eoc_cnt;
		logic busy;
		logic eoc_n;
		logic [WORD_W-1:0] word;
		logic word_tog;
		logic word_fresh;
		logic m_active;
		logic [DIV_W-1:0] div_cnt;
		logic sclk_ph;
		logic [WORD_W-1:0] m_shreg;
		logic [BIT_CNT_W-1:0] m_cnt;
		logic m_sdo;
		logic sync_q;
		logic sclk_q;
		logic [PIN_HI-PIN_LO:0] par_q;
	} dadc_ctrl_state_type;

	dadc_ctrl_state_type s;
	dadc_ctrl_state_type next_s;
	logic [PS_W-1:0] ps;
	logic link_sdo;
	logic link_flag;
	logic abort;
	logic read_en;
	logic ser_mode;
	logic ext_clk;
	logic conv_done;
	logic m_go;
	logic period_end;

	logic half_end;
	logic [PS_W-1:0] pin_raw;
	logic link_rst_n;

	// pin order follows the package positions
	assign pin_raw[PS_RESET] = reset_in;
	assign pin_raw[PS_PD] = power_down_in;
	assign pin_raw[PS_CS_N] = cs_n;
	assign pin_raw[PS_RD_N] = rd_n;
	assign pin_raw[PS_SER] = serial_parallel_select;
	assign pin_raw[PS_EXT] = clock_source_select;
	assign pin_raw[PS_INV] = serial_clock_invert;
	assign pin_raw[PS_POL] = frame_sync_polarity;
	assign pin_raw[PS_ORDER] = channel_order_select;

	// every control pin except conv_start passes two flops first
	dadc_sync2 #(.W(PS_W)) u_pin_sync (
		.clk(sys_clk),
		.d(pin_raw),
		.q(ps)
	);

	assign link_rst_n = rst_n && !reset_in;

	// slave shifter runs on the host clock
	dadc_slave_link u_slave_link (
		.link_clk(link_clk),
		.rst_n(link_rst_n),
		.word_in(s.word),
		.word_tog(s.word_tog),
		.cs_n(cs_n),
		.rd_n(rd_n),
		.serial_clock_invert(serial_clock_invert),
		.serial_data_out(link_sdo),
		.incomplete_read_flag(link_flag)
	);

	assign read_en = !ps[PS_CS_N] && !ps[PS_RD_N];
	assign abort = ps[PS_RESET];
	assign ser_mode = ps[PS_SER];
	assign ext_clk = ps[PS_EXT];
	assign conv_done = s.cv_state == CV_CH_B
		&& s.cv_cnt == CONV_CNT_W'(CH_CONV_CYC - 1);
	// a word is read once per conversion
	assign m_go = ser_mode && !ext_clk && read_en && !s.busy
		&& s.word_fresh && !s.m_active;
	// divider wraps every half period
	assign half_end = s.div_cnt == DIV_W'(SCLK_HALF_CYC - 1);
	assign period_end = half_end && s.sclk_ph;

	always_comb
	begin
		next_s = s;
		// conversion sequencer
		case (s.cv_state)
			CV_IDLE:
			begin
				if (conv_start && !ps[PS_PD] && !abort)
				begin
					next_s.cv_state = CV_CH_A;
					next_s.cv_cnt = '0;
					next_s.busy = 1'b1;
				end
			end

			CV_CH_A:
			begin
				if (s.cv_cnt == CONV_CNT_W'(CH_CONV_CYC - 1))
				begin
					next_s.cv_state = CV_CH_B;
					next_s.cv_cnt = '0;
					next_s.eoc_n = 1'b0;
					next_s.eoc_cnt = '0;
				end
				else
				begin
					next_s.cv_cnt = s.cv_cnt + 1'b1;
				end
			end

			CV_CH_B:
			begin
				if (conv_done)
				begin
					next_s.cv_state = CV_IDLE;
					next_s.cv_cnt = '0;
					next_s.eoc_n = 1'b0;
					next_s.eoc_cnt = '0;
					next_s.word = ps[PS_ORDER]
						? {ch_b_result, ch_a_result}
						: {ch_a_result, ch_b_result};
					// word and toggle change together; the link
					// reads the word only after the toggle crossed
					next_s.word_tog = ~s.word_tog;
					next_s.word_fresh = 1'b1;
					next_s.busy = 1'b0;
				end
				else
				begin
					next_s.cv_cnt = s.cv_cnt + 1'b1;
				end
			end

			default:
			begin
				next_s.cv_state = CV_IDLE;
				next_s.busy = 1'b0;
			end
		endcase

		// end of conversion low time
		// counts from the cycle eoc went low
		if (!s.eoc_n)
		begin
			if (s.eoc_cnt == EOC_CNT_W'(EOC_LOW_CYC - 1))
			begin
				next_s.eoc_n = 1'b1;
			end
			else
			begin
				next_s.eoc_cnt = s.eoc_cnt + 1'b1;
			end
		end

		// master mode serial read
		// sclk period is two half counts; data moves at period start
		if (m_go)
		begin
			next_s.m_active = 1'b1;
			next_s.word_fresh = 1'b0;
			next_s.m_sdo = s.word[WORD_W-1];
			next_s.m_shreg = {s.word[WORD_W-2:0], 1'b0};
			next_s.m_cnt = BIT_CNT_W'(1);
			next_s.div_cnt = '0;
			next_s.sclk_ph = 1'b0;
		end
		else if (s.m_active)
		begin
			if (!read_en || !ser_mode || ext_clk)
			begin
				next_s.m_active = 1'b0;
				next_s.sclk_ph = 1'b0;
			end
			else if (half_end)
			begin
				next_s.div_cnt = '0;
				next_s.sclk_ph = ~s.sclk_ph;
				if (period_end)
				begin
					if (s.m_cnt == WORD_BITS)
					begin
						next_s.m_active = 1'b0;
					end
					else
					begin
						next_s.m_sdo = s.m_shreg[WORD_W-1];
						next_s.m_shreg = {s.m_shreg[WORD_W-2:0], 1'b0};
						next_s.m_cnt = s.m_cnt + 1'b1;
					end
				end
			end
			else
			begin
				next_s.div_cnt = s.div_cnt + 1'b1;
			end
		end

		if (abort)
		begin
			next_s.cv_state = CV_IDLE;
			next_s.cv_cnt = '0;
			next_s.busy = 1'b0;
			next_s.eoc_n = 1'b1;
			next_s.word_fresh = 1'b0;
			next_s.m_active = 1'b0;
			next_s.sclk_ph = 1'b0;
			// abort also drops any serial word not yet read
			next_s.eoc_cnt = '0;
			next_s.div_cnt = '0;
			next_s.m_cnt = '0;
			next_s.m_sdo = 1'b0;
		end

		// gap falls on the first bit of the second channel
		// frame active with gap
		next_s.sync_q = (next_s.m_active && next_s.m_cnt != GAP_BIT)
			^ ps[PS_POL];

		next_s.sclk_q = (next_s.m_active && next_s.sclk_ph) ^ ps[PS_INV];

		next_s.par_q = s.word[WORD_W-1 -: PIN_HI-PIN_LO+1];
	end

	// reset keeps end of conversion at its idle high level
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.eoc_n <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	// shared pin multiplexing
	// unused serial pins are parked low and undriven
	always_comb
	begin
		upper_out = s.par_q;
		upper_oe = '0;
		if (!ser_mode)
		begin
			upper_oe = {(PIN_HI-PIN_LO+1){read_en}};
		end
		else
		begin
			upper_oe[PIN_HI:PIN_SER_LO] = '0;
			upper_out[PIN_HI:PIN_SER_LO] = '0;

			upper_oe[PIN_SERIAL_DATA_OUT] = read_en;
			upper_out[PIN_SERIAL_DATA_OUT] = ext_clk ? link_sdo : s.m_sdo;

			upper_oe[PIN_SCLK] = !ext_clk;
			upper_out[PIN_SCLK] = !ext_clk && s.sclk_q;

			upper_oe[PIN_SYNC] = !ext_clk;
			upper_out[PIN_SYNC] = !ext_clk && s.sync_q;

			upper_oe[PIN_FLAG] = ext_clk;
			upper_out[PIN_FLAG] = ext_clk && link_flag;
		end
	end

	assign busy = s.busy;
	assign end_of_conv_n = s.eoc_n;
	// low power only once the sequencer is idle
	// conversions inhibited
	assign power_saving = ps[PS_PD] && s.cv_state == CV_IDLE;
endmodule : dadc_port_ctrl

// File: rtl/dadc_pkg.sv
package dadc_pkg;
	// timing
	localparam int SYS_CLK_MHZ = 200;
	localparam int CH_CONV_NS = 500;
	localparam int CH_CONV_CYC = CH_CONV_NS * SYS_CLK_MHZ / 1000;
	localparam int EOC_LOW_NS = 20;
	localparam int EOC_LOW_CYC = (EOC_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int SCLK_HALF_NS = 20;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS * SYS_CLK_MHZ / 1000;
	localparam int CONV_CNT_W = 8;
	localparam int EOC_CNT_W = 3;
	localparam int DIV_W = 3;
	// widths and shift sequence
	localparam int RES_W = 16;
	localparam int WORD_W = 32;
	localparam int BIT_CNT_W = 6;
	localparam logic [5:0] WORD_BITS = 6'h20;
	localparam logic [5:0] GAP_BIT = 6'h11;
	// shared pin positions on the upper data bus
	localparam int PIN_LO = 8;
	localparam int PIN_HI = 15;
	localparam int PIN_SERIAL_DATA_OUT = 8;
	localparam int PIN_SCLK = 9;
	localparam int PIN_SYNC = 10;
	localparam int PIN_FLAG = 11;
	localparam int PIN_SER_LO = 12;
	// synchronised control pins
	localparam int PS_RESET = 0;
	localparam int PS_PD = 1;
	localparam int PS_CS_N = 2;
	localparam int PS_RD_N = 3;
	localparam int PS_SER = 4;
	localparam int PS_EXT = 5;
	localparam int PS_INV = 6;
	localparam int PS_POL = 7;
	localparam int PS_ORDER = 8;
	localparam int PS_W = 9;
	// link-side synchronised inputs
	localparam int LS_RST_N = 0;
	localparam int LS_TOG = 1;
	localparam int LS_CS_N = 2;
	localparam int LS_RD_N = 3;
	localparam int LS_INV = 4;
	localparam int LS_W = 5;

	typedef enum logic [1:0]
	{
		CV_IDLE = 2'b00,
		CV_CH_A = 2'b01,
		CV_CH_B = 2'b10
	} dadc_conv_state_type;
endpackage : dadc_pkg

// File: rtl/dadc_sync2.sv
`timescale 1ns/1ps
module dadc_sync2
#(
	parameter int W = 1
)
(
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dadc_sync_state_type;

	dadc_sync_state_type s;
	dadc_sync_state_type next_s;

	always_comb
	begin
		next_s.meta = d;
		next_s.stable = s.meta;
	end

	always_ff @(posedge clk)
	begin
		s <= next_s;
	end

	assign q = s.stable;
endmodule : dadc_sync2

// File: rtl/dadc_slave_link.sv
`timescale 1ns/1ps
module dadc_slave_link
	import dadc_pkg::*;
(
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic [WORD_W-1:0] word_in,
	input wire logic word_tog,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic serial_clock_invert,
	output logic serial_data_out,
	output logic incomplete_read_flag
);
	typedef struct packed {
		logic tog_seen;
		logic loaded;
		logic [WORD_W-1:0] shreg;
		logic [BIT_CNT_W-1:0] cnt;
		logic sdo_pos;
		logic err;
	} dadc_link_state_type;

	dadc_link_state_type s;
	dadc_link_state_type next_s;
	logic [LS_W-1:0] ls;
	logic sdo_neg;

	dadc_sync2 #(.W(LS_W)) u_link_sync (
		.clk(link_clk),
		.d({serial_clock_invert, rd_n, cs_n, word_tog, rst_n}),
		.q(ls)
	);

	always_comb
	begin
		next_s = s;
		next_s.err = 1'b0;
		next_s.tog_seen = ls[LS_TOG];
		if (ls[LS_TOG] != s.tog_seen)
		begin
			if (s.loaded && s.cnt != '0)
				next_s.err = 1'b1;
			next_s.shreg = word_in;
			next_s.cnt = '0;
			next_s.loaded = 1'b1;
		end
		else if (!ls[LS_CS_N] && !ls[LS_RD_N] && s.loaded)
		begin
			next_s.sdo_pos = s.shreg[WORD_W-1];
			next_s.shreg = {s.shreg[WORD_W-2:0], 1'b0};
			next_s.cnt = s.cnt + 1'b1;
			if (s.cnt == WORD_BITS - 1'b1)
				next_s.loaded = 1'b0;
		end
		if (!ls[LS_RST_N])
		begin
			next_s = '0;
			next_s.tog_seen = ls[LS_TOG];
		end
	end

	always_ff @(posedge link_clk)
	begin
		s <= next_s;
	end

	always_ff @(negedge link_clk)
	begin
		sdo_neg <= s.sdo_pos;
	end

	assign serial_data_out = ls[LS_INV] ? sdo_neg : s.sdo_pos;
	assign incomplete_read_flag = s.err;
endmodule : dadc_slave_link

// File: tb/dadc_props.sv
`timescale 1ns/1ps
module dadc_props
	import dadc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic reset_in,
	input wire logic conv_start,
	input wire logic serial_parallel_select,
	input wire logic clock_source_select,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic busy,
	input wire logic end_of_conv_n,
	input wire logic power_saving,
	input wire logic [PIN_HI:PIN_LO] upper_oe
);
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n || reset_in);
	start_busy_a: assert property (
		conv_start && !busy && !power_saving |=> busy)
		else $error("busy did not rise on start");
	eoc_delay_a: assert property (
		$rose(busy) |-> ##[99:101] $fell(end_of_conv_n))
		else $error("first end of conversion late");
	eoc_width_a: assert property (
		$fell(end_of_conv_n) |-> !end_of_conv_n [*4] ##1 end_of_conv_n)
		else $error("end of conversion width wrong");
	busy_done_a: assert property (
		$fell(busy) |-> $fell(end_of_conv_n))
		else $error("busy fell before second result");
	pd_block_a: assert property (
		power_saving && conv_start |=> !busy)
		else $error("start taken in power down");
	par_bus_a: assert property (
		(!serial_parallel_select && !cs_n && !rd_n) [*4] |-> &upper_oe)
		else $error("parallel bus not driven");
	bus_idle_a: assert property (
		cs_n [*4] |-> !upper_oe[PIN_SERIAL_DATA_OUT])
		else $error("data pin driven while deselected");
	ser_float_a: assert property (
		serial_parallel_select [*4] |-> upper_oe[15:12] == 4'h0)
		else $error("upper bits driven in serial mode");
	master_pin_a: assert property (
		(serial_parallel_select && !clock_source_select) [*4]
		|-> upper_oe[11:9] == 3'h3)
		else $error("master pin directions wrong");
	slave_pin_a: assert property (
		(serial_parallel_select && clock_source_select) [*4]
		|-> upper_oe[11:9] == 3'h4)
		else $error("slave pin directions wrong");
	abort_a: assert property (disable iff (!rst_n)
		reset_in [*6] |-> !busy && end_of_conv_n)
		else $error("conversion not aborted");
	cover property ($fell(busy));
	cover property (power_saving && conv_start);
	cover property (serial_parallel_select && clock_source_select && !cs_n);
endmodule : dadc_props

// File: tb/dadc_host.sv
`timescale 1ns/1ps
module dadc_host
(
	output logic link_clk,
	output logic cs_n,
	output logic rd_n,
	input wire logic invert,
	input wire logic sdo
);
	logic [63:0] hist;
	initial
	begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
		hist = 64'h0;
	end
	task sel(input logic v);
		cs_n = v;
		rd_n = v;
	endtask : sel
	// host clock, sample on valid edge
	task pulses(input int n);
		for (int i = 0; i < n; i++)
		begin
			#62.5;
			if (invert)
				hist = {hist[62:0], sdo};
			link_clk = 1'b1;
			#62.5;
			if (!invert)
				hist = {hist[62:0], sdo};
			link_clk = 1'b0;
		end
	endtask : pulses
	task frame(input int n);
		hist = 64'h0;
		sel(1'b0);
		pulses(n);
	endtask : frame
endmodule : dadc_host

// File: tb/dadc_port_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
$display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module dadc_port_ctrl_bench;
	logic sys_clk = 1'b0, flag_seen = 1'b0;
	logic rst_n, reset_in, power_down_in, conv_start;
	logic [15:0] ch_a_result, ch_b_result;
	logic channel_order_select, serial_parallel_select;
	logic clock_source_select, serial_clock_invert, frame_sync_polarity;
	logic cs_n, rd_n, link_clk, busy, end_of_conv_n, power_saving;
	logic [15:8] upper_out, upper_oe;
	logic [31:0] bits, syncs;
	int num_errors = 0, total_checks = 0, eoc_falls = 0;
	dadc_port_ctrl dut (.sys_clk, .rst_n, .link_clk, .reset_in,
		.power_down_in, .conv_start, .ch_a_result, .ch_b_result,
		.channel_order_select, .serial_parallel_select,
		.clock_source_select, .serial_clock_invert, .frame_sync_polarity,
		.cs_n, .rd_n, .busy, .end_of_conv_n, .power_saving, .upper_out,
		.upper_oe);
	dadc_host host (.link_clk(link_clk), .cs_n(cs_n), .rd_n(rd_n),
		.invert(serial_clock_invert),
		.sdo(upper_oe[8] ? upper_out[8] : ~upper_out[8]));
	always #2.5 sys_clk = ~sys_clk;
	always @(negedge end_of_conv_n) eoc_falls++;
	always @(posedge upper_out[11]) if (clock_source_select) flag_seen = 1'b1;
	task tick;
		@(posedge sys_clk);
		#1;
	endtask : tick
	task start;
		conv_start = 1'b1;
		tick;
		conv_start = 1'b0;
		tick;
	endtask : start
	task wait_idle;
		for (int c = 0; c < 300 && busy !== 1'b0; c++)
			tick;
	endtask : wait_idle
	task conv(input logic [15:0] a, input logic [15:0] b);
		int n;
		n = eoc_falls;
		ch_a_result = a;
		ch_b_result = b;
		start;
		wait_idle;
		`CHK(busy, 1'b0)
		`CHK(eoc_falls - n, 2)
	endtask : conv
	task par_read(input logic [7:0] e);
		host.sel(1'b0);
		repeat (5) tick;
		`CHK(upper_oe, 8'hff)
		`CHK(upper_out, e)
		host.sel(1'b1);
		repeat (5) tick;
		`CHK(upper_oe, 8'h00)
	endtask : par_read
	task master_read(input logic p, input logic [31:0] w);
		frame_sync_polarity = p;
		conv(w[31:16], w[15:0]);
		host.sel(1'b0);
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge upper_out[9]);
			bits[i] = upper_out[8];
			syncs[i] = upper_out[10];
		end
		tick;
		host.sel(1'b1);
		`CHK(bits, w)
		`CHK(syncs, {32{p}} ^ 32'hffff7fff)
	endtask : master_read
	task find(input logic [31:0] w);
		logic hit;
		hit = 1'b0;
		host.sel(1'b1);
		for (int k = 0; k < 13; k++)
			if (host.hist[k +: 32] === w)
				hit = 1'b1;
		`CHK(hit, 1'b1)
	endtask : find
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		#200000;
		num_errors++;
		give_verdict;
	end
	initial
	begin
		rst_n = 1'b0;
		reset_in = 1'b0;
		power_down_in = 1'b0;
		conv_start = 1'b0;
		ch_a_result = 16'h0;
		ch_b_result = 16'h0;
		channel_order_select = 1'b0;
		serial_parallel_select = 1'b0;
		clock_source_select = 1'b0;
		serial_clock_invert = 1'b0;
		frame_sync_polarity = 1'b0;
		// link side also needs reset edges
		host.pulses(3);
		tick;
		rst_n = 1'b1;
		repeat (3) tick;
		conv(16'hc3a5, 16'h5a3c);
		par_read(8'hc3);
		channel_order_select = 1'b1;
		conv(16'hc3a5, 16'h5a3c);
		par_read(8'h5a);
		channel_order_select = 1'b0;
		serial_parallel_select = 1'b1;
		master_read(1'b0, 32'h9a5c36e1);
		master_read(1'b1, 32'h5c93a1e6);
		clock_source_select = 1'b1;
		for (int v = 0; v < 2; v++)
		begin
			serial_clock_invert = v[0];
			conv(16'hb4d2, 16'h1e87 ^ v[15:0]);
			host.pulses(6);
			host.frame(40);
			find({16'hb4d2, 16'h1e87 ^ v[15:0]});
		end
		serial_clock_invert = 1'b0;
		conv(16'h3311, 16'h4422);
		host.pulses(6);
		host.frame(8);
		flag_seen = 1'b0;
		conv(16'h7e19, 16'h2c64);
		host.frame(44);
		find(32'h7e192c64);
		`CHK(flag_seen, 1'b1)
		serial_parallel_select = 1'b0;
		start;
		repeat (20) tick;
		reset_in = 1'b1;
		repeat (10) tick;
		`CHK(busy, 1'b0)
		`CHK(end_of_conv_n, 1'b1)
		reset_in = 1'b0;
		repeat (5) tick;
		eoc_falls = 0;
		start;
		repeat (10) tick;
		power_down_in = 1'b1;
		wait_idle;
		`CHK(eoc_falls, 2)
		repeat (5) tick;
		start;
		repeat (5) tick;
		`CHK(busy, 1'b0)
		`CHK(power_saving, 1'b1)
		give_verdict;
	end
endmodule : dadc_port_ctrl_bench
bind dadc_port_ctrl dadc_props props (.sys_clk, .rst_n, .reset_in,
	.conv_start, .serial_parallel_select, .clock_source_select, .cs_n,
	.rd_n, .busy, .end_of_conv_n, .power_saving, .upper_oe);
